// *** common/host_bus_params.svh ***
// Offsets, field positions, reset values and timing counts of the host bus control block
`ifndef HOST_BUS_PARAMS_SVH
`define HOST_BUS_PARAMS_SVH

`define HOST_BUS_CONTROL_OFS        9'h116
`define DIAG_TEST_CONTROL_OFS       9'h118
`define HOST_BUS_STATUS_OFS         9'h138
`define TDR_COUNT_OFS               9'h13c

`define HOST_BUS_CONTROL_RST        16'h0017
`define DIAG_TEST_CONTROL_RST       16'h0019
`define HOST_BUS_STATUS_RST         16'h0018
`define TDR_COUNT_RST               16'h001c
`define ID_MASK                     16'h003f

`define BC_RX_DMA_RESTART           6
`define BC_EARLY_RELEASE            8
`define BC_INTERNAL_DECODE          9
`define BC_MEMORY_MODE_ALLOW        10
`define BC_BURST_LIMIT              11
`define BC_READY_PIN_DISABLE        12
`define BC_RX_DMA_BUFFER_SIZE       13
`define BC_IRQ_ALLOW                15
`define BS_TX_REJECTED              7
`define TC_LINK_CHECK_OVERRIDE      7
`define TC_CODEC_LOOPBACK           9
`define TC_ATTACH_LOOPBACK          10
`define TC_BACKOFF_OFF              11
`define TC_FULL_DUPLEX              14

`define MAX_FRAME_WITH_FCS          16'd1514
`define MAX_FRAME_NO_FCS            16'd1518

`define CLK_FREQ_HZ                 125000000
`define BURST_LIMIT_NS              28000
`define BUS_RELEASE_NS              1300
`define TDR_RATE_HZ                 10000000
// Longest time rounds down, least time rounds up
`define BURST_LIMIT_CYCLES  ((`BURST_LIMIT_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
`define BUS_RELEASE_CYCLES  ((`BUS_RELEASE_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define TDR_DIV_CYCLES      (`CLK_FREQ_HZ / `TDR_RATE_HZ)
`define RX_BUF_64K_LIMIT    17'h10000
`define RX_BUF_16K_LIMIT    17'h04000

`endif

// *** common/host_bus_pkg.sv ***
// Types shared by the host bus control block
`default_nettype none
package host_bus_pkg;

  typedef struct packed {
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [15:0] writedata;
  } avalon_req_s;

  typedef struct packed {
    logic        codec_internal_loopback;
    logic        attachment_port_loopback;
    logic        backoff_off;
    logic        full_duplex_sel;
    logic        mac_enable;
    logic        send_link_pulses;
  } mac_ctrl_s;

  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_ACTIVE,
    DMA_RELEASE
  } dma_state_e;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_DONE
  } ready_state_e;

endpackage
`default_nettype wire

// *** core/host_bus_and_test_control.sv ***
// Host bus control, bus status, diagnostic test control and reflectometer counter
`include "host_bus_params.svh"
`default_nettype none

// Function
// R01 - Restart bit aborts receive DMA, flushes receive buffers, zeroes DMA offset pointer.
// R02 - Early release drops DMA request on last read strobe fall; single-transfer mode.
// R03 - Host DMA keeps acknowledge until request drops in demand mode.
// R04 - Internal decode: memory select needs address bits 12-19 match and chip select low.
// R05 - Memory select driven only in memory mode with memory-mode allow set.
// R06 - Memory access only with allow bit; I/O access always available.
// R07 - Burst limit caps each DMA access at 28us, then 1.3us bus release.
// R08 - Ready pin disable floats ready; otherwise stretch only I/O and memory reads.
// R09 - Receive DMA buffer is 64 Kbytes when size bit set, else 16 Kbytes.
// R10 - Interrupts pass only while interrupt allow bit is set.
// R11 - Bus control reads identifier 010111 low; resets to 0x0017, loader may override.
// R12 - Reject transmit over 1514 bytes with FCS appended, or over 1518 bytes.
// R13 - Too short transmit frames never set the rejected flag.
// R14 - Bus status reads identifier 011000 low; resets to 0x0018.
// R15 - Test control reads identifier 011001 low; resets to 0x0019, loader may override.
// R16 - Link down without override blocks packets and sends link pulses; override lets flow.
// R17 - Codec loopback routes encoder to decoder, disables line transmitters and receivers.
// R18 - Attachment-port loopback accepts reception while transmitting on that port.
// R19 - Backoff-off skips backoff, waiting only for inter-packet gap.
// R20 - Full duplex ignores carrier sense; clear means half duplex.
// R21 - Software sets full duplex before twisted-pair loopback tests.
// R22 - Reflectometer counts at 10 MHz from port transmit start to error; clears on read. Code ticks every 12 clocks, 10.4 MHz.
module host_bus_and_test_control (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Avalon-MM slave
  input  wire logic [8:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [15:0]             avs_writedata,
  output logic      [15:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Configuration loader override
  input  wire logic                    cfg_load,
  input  wire logic [15:0]             cfg_bus_control,
  input  wire logic [15:0]             cfg_test_control,
  // ISA side memory decode
  input  wire logic                    chip_select_in_n,
  input  wire logic [7:0]              sa_high,
  input  wire logic [7:0]              mem_base_high,
  input  wire logic                    memory_mode,
  input  wire logic                    mem_access_req,
  output logic                         mem_cs16_n_out,
  output logic                         mem_cs16_n_oe,
  output logic                         mem_access_allow,
  // Channel ready, open drain
  input  wire logic                    host_io_read,
  input  wire logic                    host_mem_read,
  input  wire logic                    read_data_pending,
  output logic                         chan_ready_out,
  output logic                         chan_ready_oe,
  // Receive DMA
  input  wire logic                    rx_frame_pending,
  input  wire logic                    dma_ack_in,
  input  wire logic                    ior_n,
  input  wire logic                    dma_last_read,
  output logic                         dma_request_out,
  output logic                         single_transfer_mode,
  output logic                         rx_dma_abort,
  output logic                         rx_buffer_flush,
  output logic      [15:0]             rx_dma_offset,
  // Interrupt gating
  input  wire logic                    irq_event,
  output logic                         irq_out,
  // Transmit request check
  input  wire logic                    tx_cmd_valid,
  input  wire logic [15:0]             tx_cmd_length,
  input  wire logic                    fcs_append_inhibit,
  output logic                         tx_cmd_accept,
  // MAC and line control
  input  wire logic                    link_good,
  input  wire logic                    aui_tx_start,
  input  wire logic                    aui_tx_error,
  output host_bus_pkg::mac_ctrl_s      mac_ctrl
);

  logic [15:0]                 host_bus_control;
  logic [15:0]                 diagnostic_test_control;
  logic                        tx_request_rejected;
  logic [9:0]                  tdr_delay_count;
  logic                        tdr_running;
  logic [3:0]                  tdr_div;
  logic                        tdr_tick;
  logic                        read_ack;
  logic                        write_ack;
  host_bus_pkg::dma_state_e    dma_state;
  logic [12:0]                 dma_timer;
  logic                        ior_n_q;
  logic [16:0]                 next_dma_offset;
  logic [16:0]                 rx_buf_limit;
  host_bus_pkg::ready_state_e  ready_state;

  function automatic logic reg_hit(input logic [8:0] addr, input logic [8:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Writes complete at once; reads take one wait cycle to register data
  assign write_ack       = avs_write;
  assign avs_waitrequest = avs_read & ~read_ack;

  // Software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_bus_control        <= `HOST_BUS_CONTROL_RST;                          // R11
      diagnostic_test_control <= `DIAG_TEST_CONTROL_RST;                         // R15
    end else if (cfg_load) begin
      host_bus_control        <= (cfg_bus_control & ~`ID_MASK) | `HOST_BUS_CONTROL_RST;
      diagnostic_test_control <= (cfg_test_control & ~`ID_MASK) | `DIAG_TEST_CONTROL_RST;
    end else begin
      // Restart bit self clears so it acts as a command
      host_bus_control[`BC_RX_DMA_RESTART] <= 1'b0;
      if (write_ack && reg_hit(avs_address, `HOST_BUS_CONTROL_OFS))
        host_bus_control <= (avs_writedata & ~`ID_MASK) | `HOST_BUS_CONTROL_RST;  // R11
      if (write_ack && reg_hit(avs_address, `DIAG_TEST_CONTROL_OFS))
        diagnostic_test_control <= (avs_writedata & ~`ID_MASK) | `DIAG_TEST_CONTROL_RST; // R15
    end
  end

  // Read path; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_ack     <= 1'b0;
      avs_readdata <= 16'h0000;
    end else begin
      read_ack <= avs_read & ~read_ack;
      if (avs_read && !read_ack) begin
        unique case (avs_address)
          `HOST_BUS_CONTROL_OFS:  avs_readdata <= host_bus_control;
          `DIAG_TEST_CONTROL_OFS: avs_readdata <= diagnostic_test_control;
          `HOST_BUS_STATUS_OFS:                                                  // R14
            avs_readdata <= `HOST_BUS_STATUS_RST | (16'(tx_request_rejected) << `BS_TX_REJECTED);
          `TDR_COUNT_OFS:         avs_readdata <= {tdr_delay_count, 6'h1c};      // R22
          default:                avs_readdata <= 16'h0000;
        endcase
      end
    end
  end

  // Transmit request screening
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_request_rejected <= 1'b0;
    end else if (tx_cmd_valid) begin
      // Short frames are another block's concern and never flag here
      tx_request_rejected <= (tx_cmd_length > `MAX_FRAME_NO_FCS) ||             // R12 R13
                             (!fcs_append_inhibit && tx_cmd_length > `MAX_FRAME_WITH_FCS);
    end
  end
  assign tx_cmd_accept = tx_cmd_valid && !(tx_cmd_length > `MAX_FRAME_NO_FCS) &&
                         !(!fcs_append_inhibit && tx_cmd_length > `MAX_FRAME_WITH_FCS); // R12

  // Enable every 12 clocks (10.4 MHz) for the reflectometer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdr_div <= 4'h0;
    end else if (tdr_div == 4'(`TDR_DIV_CYCLES - 1)) begin
      tdr_div <= 4'h0;
    end else begin
      tdr_div <= tdr_div + 4'h1;
    end
  end
  assign tdr_tick = (tdr_div == 4'(`TDR_DIV_CYCLES - 1));

  // Reflectometer counter; a count in the read cycle is lost to the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdr_running     <= 1'b0;
      tdr_delay_count <= 10'h000;
    end else begin
      if (aui_tx_start)
        tdr_running <= 1'b1;
      else if (aui_tx_error)
        tdr_running <= 1'b0;
      if (read_ack && reg_hit(avs_address, `TDR_COUNT_OFS))
        tdr_delay_count <= 10'h000;                                              // R22
      else if (aui_tx_start)
        tdr_delay_count <= 10'h000;
      else if (tdr_running && !aui_tx_error && tdr_tick && tdr_delay_count != 10'h3ff)
        tdr_delay_count <= tdr_delay_count + 10'h001;                            // R22
    end
  end

  // Memory decode
  always_comb begin
    mem_access_allow = host_bus_control[`BC_MEMORY_MODE_ALLOW];                  // R06
    mem_cs16_n_oe    = memory_mode && host_bus_control[`BC_MEMORY_MODE_ALLOW];   // R05
    if (host_bus_control[`BC_INTERNAL_DECODE])
      mem_cs16_n_out = !(!chip_select_in_n && sa_high == mem_base_high);         // R04
    else
      mem_cs16_n_out = chip_select_in_n;                                         // R04
  end

  // Channel ready stretches reads only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_state <= host_bus_pkg::RD_IDLE;
    end else begin
      unique case (ready_state)
        host_bus_pkg::RD_IDLE:
          if ((host_io_read || (host_mem_read && mem_access_req)) && read_data_pending)
            ready_state <= host_bus_pkg::RD_WAIT;
        host_bus_pkg::RD_WAIT:
          if (!read_data_pending)
            ready_state <= host_bus_pkg::RD_DONE;
        host_bus_pkg::RD_DONE:
          if (!host_io_read && !host_mem_read)
            ready_state <= host_bus_pkg::RD_IDLE;
      endcase
    end
  end
  assign chan_ready_out = 1'b0;
  assign chan_ready_oe  = !host_bus_control[`BC_READY_PIN_DISABLE] &&            // R08
                          ready_state == host_bus_pkg::RD_WAIT;

  // Receive DMA request with burst limiting
  assign rx_buf_limit = host_bus_control[`BC_RX_DMA_BUFFER_SIZE] ?               // R09
                        `RX_BUF_64K_LIMIT : `RX_BUF_16K_LIMIT;
  assign rx_dma_abort    = host_bus_control[`BC_RX_DMA_RESTART];                 // R01
  assign rx_buffer_flush = host_bus_control[`BC_RX_DMA_RESTART];                 // R01
  assign single_transfer_mode = host_bus_control[`BC_EARLY_RELEASE];             // R02

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ior_n_q <= 1'b1;
    end else begin
      ior_n_q <= ior_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_state       <= host_bus_pkg::DMA_IDLE;
      dma_timer       <= 13'h0000;
      dma_request_out <= 1'b0;
    end else if (rx_dma_abort) begin
      dma_state       <= host_bus_pkg::DMA_IDLE;                                 // R01
      dma_timer       <= 13'h0000;
      dma_request_out <= 1'b0;
    end else begin
      unique case (dma_state)
        host_bus_pkg::DMA_IDLE: begin
          dma_timer <= 13'h0000;
          if (rx_frame_pending) begin
            dma_state       <= host_bus_pkg::DMA_ACTIVE;
            dma_request_out <= 1'b1;
          end
        end
        host_bus_pkg::DMA_ACTIVE: begin
          dma_timer <= dma_timer + 13'h0001;
          // Early release drops on last strobe fall, else on its rise
          if (dma_last_read && dma_ack_in &&
              (host_bus_control[`BC_EARLY_RELEASE] ? (ior_n_q && !ior_n)          // R02
                                                   : (!ior_n_q && ior_n))) begin
            dma_request_out <= 1'b0;                                             // R03
            dma_state       <= host_bus_pkg::DMA_IDLE;
          end else if (host_bus_control[`BC_BURST_LIMIT] &&
                       dma_timer == 13'(`BURST_LIMIT_CYCLES - 1)) begin
            dma_request_out <= 1'b0;                                             // R07
            dma_state       <= host_bus_pkg::DMA_RELEASE;
            dma_timer       <= 13'h0000;
          end
        end
        host_bus_pkg::DMA_RELEASE: begin
          dma_timer <= dma_timer + 13'h0001;
          if (dma_timer == 13'(`BUS_RELEASE_CYCLES - 1)) begin
            dma_state <= host_bus_pkg::DMA_IDLE;                                 // R07
            dma_timer <= 13'h0000;
          end
        end
      endcase
    end
  end

  // Offset pointer wraps at buffer size
  assign next_dma_offset = {1'b0, rx_dma_offset} + 17'h00002;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dma_offset <= 16'h0000;
    end else if (rx_dma_abort) begin
      rx_dma_offset <= 16'h0000;                                                 // R01
    end else if (dma_request_out && dma_ack_in && !ior_n_q && ior_n) begin
      rx_dma_offset <= (next_dma_offset >= rx_buf_limit) ? 16'h0000              // R09
                                                          : next_dma_offset[15:0];
    end
  end

  // Interrupt gate
  assign irq_out = irq_event && host_bus_control[`BC_IRQ_ALLOW];                 // R10

  // MAC mode controls
  always_comb begin
    mac_ctrl.codec_internal_loopback  = diagnostic_test_control[`TC_CODEC_LOOPBACK];  // R17
    mac_ctrl.attachment_port_loopback = diagnostic_test_control[`TC_ATTACH_LOOPBACK]; // R18
    mac_ctrl.backoff_off              = diagnostic_test_control[`TC_BACKOFF_OFF];     // R19
    // Twisted-pair loopback relies on software selecting full duplex first
    mac_ctrl.full_duplex_sel          = diagnostic_test_control[`TC_FULL_DUPLEX];     // R20 R21
    mac_ctrl.mac_enable               = link_good ||
                                        diagnostic_test_control[`TC_LINK_CHECK_OVERRIDE]; // R16
    mac_ctrl.send_link_pulses         = !link_good &&
                                        !diagnostic_test_control[`TC_LINK_CHECK_OVERRIDE]; // R16
  end

endmodule // host_bus_and_test_control
`default_nettype wire

// *** testbench/host_bus_and_test_control_tb.sv ***
// Self-checking bench for the host bus and test control block
`default_nettype none
module host_bus_and_test_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cfg_load = 1'b0;
  logic [8:0]  avs_address = 9'h000;
  logic [15:0] avs_writedata = 16'h0000, avs_readdata, rx_dma_offset, rd;
  logic [15:0] cfg_bus_control = 16'h0000, cfg_test_control = 16'h0000;
  logic [15:0] tx_cmd_length = 16'h0000, reads_per_frame = 16'h0004;
  logic [7:0]  sa_high = 8'h00, mem_base_high = 8'h0d;
  logic        chip_select_in_n = 1'b1, memory_mode = 1'b0, mem_access_req = 1'b0;
  logic        host_io_read = 1'b0, host_mem_read = 1'b0, read_data_pending = 1'b0;
  logic        rx_frame_pending = 1'b0, irq_event = 1'b0, tx_cmd_valid = 1'b0;
  logic        fcs_append_inhibit = 1'b0, link_good = 1'b0, aui_tx_start = 1'b0;
  logic        aui_tx_error = 1'b0, avs_waitrequest, mem_cs16_n_out, mem_cs16_n_oe;
  logic        mem_access_allow, chan_ready_out, chan_ready_oe, dma_ack_in, ior_n;
  logic        dma_last_read, dma_request_out, single_transfer_mode, rx_dma_abort;
  logic        rx_buffer_flush, irq_out, tx_cmd_accept;
  host_bus_pkg::mac_ctrl_s mac_ctrl;
  int          n_errors = 0, num_checks = 0, cyc;
  always #4 clk = ~clk;
  host_bus_and_test_control DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cfg_load, .cfg_bus_control,
    .cfg_test_control, .chip_select_in_n, .sa_high, .mem_base_high, .memory_mode,
    .mem_access_req, .mem_cs16_n_out, .mem_cs16_n_oe, .mem_access_allow, .host_io_read,
    .host_mem_read, .read_data_pending, .chan_ready_out, .chan_ready_oe, .rx_frame_pending,
    .dma_ack_in, .ior_n, .dma_last_read, .dma_request_out, .single_transfer_mode,
    .rx_dma_abort, .rx_buffer_flush, .rx_dma_offset, .irq_event, .irq_out, .tx_cmd_valid,
    .tx_cmd_length, .fcs_append_inhibit, .tx_cmd_accept, .link_good, .aui_tx_start,
    .aui_tx_error, .mac_ctrl);
  isa_dma_host_model host (.clk, .rst_n, .dma_request_out, .reads_per_frame, .dma_ack_in,
    .ior_n, .dma_last_read);
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Held until an edge with waitrequest low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0) @(negedge clk);
    rd = avs_readdata;
    @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk("readdata", rd, exp);
  endtask
  task automatic t_regs;
    rdchk(9'h116, 16'h0017);
    rdchk(9'h118, 16'h0019);
    rdchk(9'h138, 16'h0018);
    rdchk(9'h13c, 16'h001c);
    rdchk(9'h120, 16'h0000);
    bus(1'b1, 9'h116, 16'h003f);
    rdchk(9'h116, 16'h0017);
    bus(1'b1, 9'h138, 16'hff80);
    rdchk(9'h138, 16'h0018);
  endtask
  task automatic t_test_ctl;
    bus(1'b1, 9'h118, 16'h4e80);
    rdchk(9'h118, 16'h4e99);
    chk("mac_ctrl", 16'(mac_ctrl), 16'h003e);
    bus(1'b1, 9'h118, 16'h0000);
    chk("mac_ctrl", 16'(mac_ctrl), 16'h0001);
    link_good <= 1'b1;
    @(posedge clk);
    chk("mac_ctrl", 16'(mac_ctrl), 16'h0002);
  endtask
  task automatic dma_frame(input logic [15:0] n, input logic exp_ior);
    reads_per_frame <= n;
    rx_frame_pending <= 1'b1;
    @(posedge dma_request_out);
    rx_frame_pending <= 1'b0;
    @(negedge dma_request_out);
    #1;
    chk("ior_at_drop", 16'(ior_n), 16'(exp_ior));
    @(posedge clk);
  endtask
  task automatic t_dma;
    dma_frame(16'h0004, 1'b1);
    chk("offset", rx_dma_offset, 16'h0008);
    bus(1'b1, 9'h116, 16'h0040);
    repeat (2) @(posedge clk);
    chk("offset", rx_dma_offset, 16'h0000);
    rdchk(9'h116, 16'h0017);
    bus(1'b1, 9'h116, 16'h0100);
    chk("single", 16'(single_transfer_mode), 16'h0001);
    dma_frame(16'h0002, 1'b0);
  endtask
  task automatic t_pins;
    bus(1'b1, 9'h116, 16'h8600);
    irq_event <= 1'b1;
    memory_mode <= 1'b1;
    chip_select_in_n <= 1'b0;
    sa_high <= 8'h0d;
    @(posedge clk);
    chk("irq", 16'(irq_out), 16'h0001);
    chk("cs16", 16'(mem_cs16_n_oe & ~mem_cs16_n_out), 16'h0001);
    sa_high <= 8'h0e;
    @(posedge clk);
    chk("cs16", 16'(mem_cs16_n_oe & ~mem_cs16_n_out), 16'h0000);
    bus(1'b1, 9'h116, 16'h0000);
    chk("irq", 16'(irq_out), 16'h0000);
    chk("cs16_oe", 16'(mem_cs16_n_oe), 16'h0000);
    chk("mem_allow", 16'(mem_access_allow), 16'h0000);
    host_io_read <= 1'b1;
    read_data_pending <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ready_oe", 16'(chan_ready_oe), 16'h0001);
    bus(1'b1, 9'h116, 16'h1000);
    chk("ready_oe", 16'(chan_ready_oe), 16'h0000);
    host_io_read <= 1'b0;
    read_data_pending <= 1'b0;
  endtask
  task automatic tx_try(input logic [15:0] len, input logic inh, input logic [15:0] exp);
    tx_cmd_length <= len;
    fcs_append_inhibit <= inh;
    tx_cmd_valid <= 1'b1;
    @(posedge clk);
    chk("accept", 16'(tx_cmd_accept), 16'(!exp[7]));
    tx_cmd_valid <= 1'b0;
    rdchk(9'h138, exp);
  endtask
  task automatic t_tdr;
    aui_tx_start <= 1'b1;
    @(posedge clk);
    aui_tx_start <= 1'b0;
    repeat (120) @(posedge clk);
    aui_tx_error <= 1'b1;
    @(posedge clk);
    aui_tx_error <= 1'b0;
    bus(1'b0, 9'h13c, 16'h0000);
    chk("tdr_count_ok", 16'(rd[15:6] inside {[10'd9:10'd10]}), 16'h0001);
    chk("tdr_id", {10'h000, rd[5:0]}, 16'h001c);
    rdchk(9'h13c, 16'h001c);
  endtask
  // Long frame; only the burst limit ends a request
  task automatic t_burst;
    bus(1'b1, 9'h116, 16'h0800);
    reads_per_frame <= 16'd3000;
    rx_frame_pending <= 1'b1;
    @(posedge dma_request_out);
    for (cyc = 0; dma_request_out === 1'b1 && cyc < 4000; cyc++) @(negedge clk);
    chk("burst_ok", 16'(cyc inside {[3498:3501]}), 16'h0001);
    for (cyc = 0; dma_request_out !== 1'b1 && cyc < 400; cyc++) @(negedge clk);
    chk("gap_ok", 16'(cyc inside {[163:200]}), 16'h0001);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_test_ctl;
    t_dma;
    t_pins;
    tx_try(16'd2, 1'b0, 16'h0018);
    tx_try(16'd1514, 1'b0, 16'h0018);
    tx_try(16'd1518, 1'b1, 16'h0018);
    tx_try(16'd1519, 1'b1, 16'h0098);
    tx_try(16'd1515, 1'b0, 16'h0098);
    t_tdr;
    t_burst;
    close_out;
  end
  // Run is a few thousand cycles; this only cuts a hang
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule // host_bus_and_test_control_tb
`default_nettype wire

// *** testbench/host_bus_checker.sv ***
// Port-level assertions for the host bus and test control block
`default_nettype none
module host_bus_checker (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Register bus
  input wire logic [8:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [15:0]             avs_writedata,
  input wire logic                    avs_waitrequest,
  // Host side pins
  input wire logic                    chip_select_in_n,
  input wire logic                    memory_mode,
  input wire logic                    mem_cs16_n_out,
  input wire logic                    mem_cs16_n_oe,
  input wire logic                    mem_access_allow,
  input wire logic                    chan_ready_out,
  input wire logic                    chan_ready_oe,
  input wire logic                    irq_event,
  input wire logic                    irq_out,
  // Receive DMA and line control
  input wire logic                    rx_dma_abort,
  input wire logic                    rx_buffer_flush,
  input wire logic [15:0]             rx_dma_offset,
  input wire logic                    link_good,
  input wire host_bus_pkg::mac_ctrl_s mac_ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence restart_write;
    avs_write && avs_address == 9'h116 && avs_writedata[6];
  endsequence
  sequence abort_pulse;
    rx_dma_abort && rx_buffer_flush ##1 !rx_dma_abort;
  endsequence
  a_restart_aborts: assert property (restart_write |-> ##[0:2] abort_pulse)
    else $error("restart write gave no abort pulse");
  a_restart_zeroes: assert property (rx_dma_abort |-> ##[0:1] rx_dma_offset == 16'h0000)
    else $error("offset not zeroed by restart");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  a_read_onewait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
  a_cs16_allow: assert property (mem_cs16_n_oe |-> memory_mode && mem_access_allow)
    else $error("memory select driven outside memory mode");
  a_cs16_chip_select_in: assert property (mem_cs16_n_oe && !mem_cs16_n_out |-> !chip_select_in_n)
    else $error("memory select without chip select");
  a_ready_pull: assert property (chan_ready_oe |-> !chan_ready_out)
    else $error("ready pin driven high");
  a_irq_gate: assert property (irq_out |-> irq_event)
    else $error("interrupt without event");
  a_link_block: assert property (!link_good && !mac_ctrl.mac_enable |-> mac_ctrl.send_link_pulses)
    else $error("no link pulses while blocked");
  a_link_good: assert property (link_good |-> mac_ctrl.mac_enable && !mac_ctrl.send_link_pulses)
    else $error("traffic blocked with good link");
endmodule // host_bus_checker

bind host_bus_and_test_control host_bus_checker u_checker (.clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .chip_select_in_n, .memory_mode, .mem_cs16_n_out,
  .mem_cs16_n_oe, .mem_access_allow, .chan_ready_out, .chan_ready_oe, .irq_event, .irq_out,
  .rx_dma_abort, .rx_buffer_flush, .rx_dma_offset, .link_good, .mac_ctrl);
`default_nettype wire

// *** testbench/isa_dma_host_model.sv ***
// Behavioural host DMA controller answering the receive DMA request
`default_nettype none
module isa_dma_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // DMA handshake
  input  wire logic        dma_request_out,
  input  wire logic [15:0] reads_per_frame,
  output logic             dma_ack_in,
  output logic             ior_n,
  output logic             dma_last_read
);
  logic [1:0]  phase;
  logic [15:0] done;
  logic        ior_q;
  // Ack held for as long as the request stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dma_ack_in <= 1'b0;
    else dma_ack_in <= dma_request_out;
  end
  // Strobe low two cycles, high two; strobe driven high while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'd0;
      ior_n <= 1'b1;
    end else if (dma_ack_in && dma_request_out) begin
      phase <= phase + 2'd1;
      ior_n <= phase[1];
    end else begin
      phase <= 2'd0;
      ior_n <= 1'b1;
    end
  end
  // Reads counted on strobe rise, frame ends on the last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ior_q <= 1'b1;
      done  <= 16'h0000;
    end else begin
      ior_q <= ior_n;
      if (ior_n && !ior_q) done <= dma_last_read ? 16'h0000 : done + 16'h0001;
    end
  end
  assign dma_last_read = dma_ack_in && (done == reads_per_frame - 16'h0001);
endmodule // isa_dma_host_model
`default_nettype wire
